// ---- src/epm_pin_mux.sv ----
module epm_pin_mux import epm_pkg::*; #(
	parameter int unsigned BLINK_LEN = BLINK_CYCLES
) (
	// Clock and control
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic CLK_EN,
	input wire logic HOST_BUS_RESET_N,
	// Configuration
	input wire logic [1:0] MEM_DATA_SEL,
	input wire logic [1:0] MEM_CLK_SEL,
	input wire logic GEN_OUTPUT_THREE,
	input wire logic GEN_OUTPUT_FOUR,
	input wire logic [2*GPIO_COUNT-1:0] GPIO_MODE,
	input wire logic [GPIO_COUNT-1:0] GPIO_OUT,
	input wire logic [GPIO_COUNT-1:0] GPIO_LED_EN,
	output logic [GPIO_COUNT-1:0] GPIO_IN_STATUS,
	output logic TEST_STRAP,
	output logic STRAP_VALID,
	// Serial memory engine
	input wire logic MEM_DO,
	input wire logic MEM_DOE,
	input wire logic MEM_CLK_OUT,
	input wire logic MEM_CS_REQ,
	output logic MEM_DATA_IN,
	// Internal media interface and link state
	input wire logic MII_TX_EN,
	input wire logic MII_TX_CLK,
	input wire logic MII_RX_DV,
	input wire logic MII_RX_CLK,
	input wire logic LINK_UP,
	input wire logic SPEED_100,
	input wire logic AUTONEG_BUSY,
	input wire logic FULL_DUPLEX,
	// Serial memory pins
	input wire logic MEM_SERIAL_DATA_PIN_I,
	output logic MEM_SERIAL_DATA_PIN_O,
	output logic MEM_SERIAL_DATA_PIN_OE,
	input wire logic MEM_SERIAL_CLOCK_PIN_I,
	output logic MEM_SERIAL_CLOCK_PIN_O,
	output logic MEM_SERIAL_CLOCK_PIN_OE,
	output logic MEM_CHIP_SELECT_PIN,
	// General-purpose pins
	input wire logic [GPIO_COUNT-1:0] GEN_IO_I,
	output logic [GPIO_COUNT-1:0] GEN_IO_O,
	output logic [GPIO_COUNT-1:0] GEN_IO_OE
);
	// Returns {oe, o} for one pin in the given mode
	function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic val);
		logic [1:0] r;
		case (mode)
			GM_PUSH: r = {1'b1, val};
			GM_OPEN: r = {~val, 1'b0};
			default: r = 2'b00;
		endcase
		return r;
	endfunction : pin_drive

	epm_blink_if blink_ifc ();
	logic [GPIO_COUNT-1:0] led_n;
	logic [GPIO_COUNT-1:0] next_gio_o, next_gio_oe, next_gin;
	logic next_d_o, next_d_oe, next_din;
	logic next_c_o, next_c_oe, next_cs;
	logic next_strap, next_strap_valid;

	// ******************************************************
	// Activity blinker
	// ******************************************************
	assign blink_ifc.act = MII_TX_EN | MII_RX_DV;
	assign blink_ifc.link = LINK_UP;

	epm_blink #(
		.BLINK_LEN(BLINK_LEN)
	) u_blink (
		.clock(CLOCK),
		.rst_b(RST_B),
		.clk_en(CLK_EN),
		.ifc(blink_ifc)
	);

	// ******************************************************
	// Indicators
	// ******************************************************
	// Released (high) only for a linked 10M link; lit at 100, while negotiating and unplugged
	assign led_n[GPIO_SPEED] = LINK_UP & ~SPEED_100 & ~AUTONEG_BUSY;
	assign led_n[GPIO_LINK] = blink_ifc.led_n;
	assign led_n[GPIO_DUPLEX] = ~FULL_DUPLEX;

	// ******************************************************
	// General-purpose pins
	// ******************************************************
	always_comb begin
		for (int i = 0; i < GPIO_COUNT; i++) begin
			// Indicator and general use never share the pin at once
			if (GPIO_LED_EN[i]) begin
				{next_gio_oe[i], next_gio_o[i]} = pin_drive(GM_OPEN, led_n[i]);
			end else begin
				{next_gio_oe[i], next_gio_o[i]} = pin_drive(GPIO_MODE[2*i +: 2], GPIO_OUT[i]);
			end
		end
		next_gin = GEN_IO_I;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			GEN_IO_O <= '0;
			GEN_IO_OE <= '0;
			GPIO_IN_STATUS <= '0;
		end else if (CLK_EN) begin
			GEN_IO_O <= next_gio_o;
			GEN_IO_OE <= next_gio_oe;
			GPIO_IN_STATUS <= next_gin;
		end
	end

	// ******************************************************
	// Serial memory pins and power-up latch
	// ******************************************************
	always_comb begin
		next_strap = TEST_STRAP;
		next_strap_valid = STRAP_VALID;
		// Level is taken on the first cycle after the bus reset lifts
		if (!STRAP_VALID && HOST_BUS_RESET_N) begin
			next_strap = MEM_SERIAL_CLOCK_PIN_I;
			next_strap_valid = 1'b1;
		end
		case (MEM_DATA_SEL)
			MSEL_GPO: {next_d_oe, next_d_o} = {1'b1, GEN_OUTPUT_THREE};
			MSEL_MII_EN: {next_d_oe, next_d_o} = {1'b1, MII_TX_EN};
			MSEL_MII_CLK: {next_d_oe, next_d_o} = {1'b1, MII_TX_CLK};
			default: {next_d_oe, next_d_o} = {MEM_DOE, MEM_DO};
		endcase
		case (MEM_CLK_SEL)
			MSEL_GPO: next_c_o = GEN_OUTPUT_FOUR;
			MSEL_MII_EN: next_c_o = MII_RX_DV;
			MSEL_MII_CLK: next_c_o = MII_RX_CLK;
			default: next_c_o = MEM_CLK_OUT;
		endcase
		// No drive until the strap has been read
		next_c_oe = next_strap_valid;
		next_cs = MEM_CS_REQ & (MEM_DATA_SEL == MSEL_MEM) & (MEM_CLK_SEL == MSEL_MEM);
		next_din = MEM_SERIAL_DATA_PIN_I;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			TEST_STRAP <= RST_STRAP;
			STRAP_VALID <= 1'b0;
			MEM_SERIAL_DATA_PIN_O <= 1'b0;
			MEM_SERIAL_DATA_PIN_OE <= 1'b0;
			MEM_SERIAL_CLOCK_PIN_O <= 1'b0;
			MEM_SERIAL_CLOCK_PIN_OE <= 1'b0;
			MEM_CHIP_SELECT_PIN <= 1'b0;
			MEM_DATA_IN <= 1'b0;
		end else if (CLK_EN) begin
			TEST_STRAP <= next_strap;
			STRAP_VALID <= next_strap_valid;
			MEM_SERIAL_DATA_PIN_O <= next_d_o;
			MEM_SERIAL_DATA_PIN_OE <= next_d_oe;
			MEM_SERIAL_CLOCK_PIN_O <= next_c_o;
			MEM_SERIAL_CLOCK_PIN_OE <= next_c_oe;
			MEM_CHIP_SELECT_PIN <= next_cs;
			MEM_DATA_IN <= next_din;
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	// Reset is part of each next-cycle trigger too: the edge that lifts it still clears the flops
	logic live_step;
	assign live_step = RST_B & CLK_EN;

	cs_guard_a: assert property (
		live_step && (MEM_DATA_SEL != MSEL_MEM || MEM_CLK_SEL != MSEL_MEM)
		|=> !MEM_CHIP_SELECT_PIN)
		else $error("chip select asserted in alternate mode");
	data_txen_a: assert property (
		live_step && MEM_DATA_SEL == MSEL_MII_EN
		|=> MEM_SERIAL_DATA_PIN_OE && MEM_SERIAL_DATA_PIN_O == $past(MII_TX_EN))
		else $error("data pin does not copy transmit enable");
	data_tclk_a: assert property (
		live_step && MEM_DATA_SEL == MSEL_MII_CLK
		|=> MEM_SERIAL_DATA_PIN_OE && MEM_SERIAL_DATA_PIN_O == $past(MII_TX_CLK))
		else $error("data pin does not copy transmit clock");
	data_mem_a: assert property (
		live_step && MEM_DATA_SEL == MSEL_MEM
		|=> MEM_SERIAL_DATA_PIN_OE == $past(MEM_DOE) && MEM_SERIAL_DATA_PIN_O == $past(MEM_DO))
		else $error("data pin does not follow memory engine");
	clk_rxdv_a: assert property (
		live_step && MEM_CLK_SEL == MSEL_MII_EN && STRAP_VALID
		|=> MEM_SERIAL_CLOCK_PIN_OE && MEM_SERIAL_CLOCK_PIN_O == $past(MII_RX_DV))
		else $error("clock pin does not copy receive valid");
	clk_gpo_a: assert property (
		live_step && MEM_CLK_SEL == MSEL_GPO && STRAP_VALID
		|=> MEM_SERIAL_CLOCK_PIN_OE && MEM_SERIAL_CLOCK_PIN_O == $past(GEN_OUTPUT_FOUR))
		else $error("clock pin does not follow general output");
	clk_input_a: assert property (MEM_SERIAL_CLOCK_PIN_OE |-> STRAP_VALID)
		else $error("clock pin driven before strap latched");
	strap_latch_a: assert property (
		live_step && !STRAP_VALID && HOST_BUS_RESET_N
		|=> STRAP_VALID && TEST_STRAP == $past(MEM_SERIAL_CLOCK_PIN_I) ##1 $stable(TEST_STRAP))
		else $error("strap not latched or not held");
	speed_led_a: assert property (
		live_step && GPIO_LED_EN[GPIO_SPEED] && SPEED_100
		|=> GEN_IO_OE[GPIO_SPEED] && !GEN_IO_O[GPIO_SPEED])
		else $error("speed indicator not low at 100");
	duplex_led_a: assert property (
		live_step && GPIO_LED_EN[GPIO_DUPLEX]
		|=> GEN_IO_OE[GPIO_DUPLEX] == $past(FULL_DUPLEX) && !GEN_IO_O[GPIO_DUPLEX])
		else $error("duplex indicator wrong");
	link_led_a: assert property (
		live_step && GPIO_LED_EN[GPIO_LINK]
		|=> GEN_IO_OE[GPIO_LINK] == !$past(blink_ifc.led_n) && !GEN_IO_O[GPIO_LINK])
		else $error("link indicator does not follow the blinker");
	gpio_mode_a: assert property (
		live_step && !GPIO_LED_EN[0] && GPIO_MODE[1:0] == GM_OPEN
		|=> !GEN_IO_O[0] && GEN_IO_OE[0] == !$past(GPIO_OUT[0]))
		else $error("open-drain mode drives wrongly");
	push_pull_a: assert property (
		live_step && !GPIO_LED_EN[GPIO_DUPLEX] && GPIO_MODE[2*GPIO_DUPLEX +: 2] == GM_PUSH
		|=> GEN_IO_OE[GPIO_DUPLEX] && GEN_IO_O[GPIO_DUPLEX] == $past(GPIO_OUT[GPIO_DUPLEX]))
		else $error("push-pull mode drives wrongly");
endmodule : epm_pin_mux

// ---- src/epm_pkg.sv ----
package epm_pkg;
	// ******************************************************
	// Serial memory pin function select codes
	// ******************************************************
	localparam logic [1:0] MSEL_MEM = 2'h0;
	localparam logic [1:0] MSEL_GPO = 2'h1;
	localparam logic [1:0] MSEL_MII_EN = 2'h2;
	localparam logic [1:0] MSEL_MII_CLK = 2'h3;

	// ******************************************************
	// General-purpose pin mode codes (3 behaves as input)
	// ******************************************************
	localparam logic [1:0] GM_INPUT = 2'h0;
	localparam logic [1:0] GM_PUSH = 2'h1;
	localparam logic [1:0] GM_OPEN = 2'h2;
	localparam int GPIO_COUNT = 3;
	localparam int GPIO_SPEED = 0;
	localparam int GPIO_LINK = 1;
	localparam int GPIO_DUPLEX = 2;

	// ******************************************************
	// Reset values
	// ******************************************************
	localparam logic RST_STRAP = 1'h1;
	localparam logic RST_LED_N = 1'h1;

	// ******************************************************
	// Activity blink timing
	// ******************************************************
	localparam int unsigned BLINK_TIME_MS = 80;
	localparam int unsigned CLOCK_FREQ_KHZ = 100000;
	localparam int unsigned BLINK_CYCLES = BLINK_TIME_MS * CLOCK_FREQ_KHZ;

	typedef enum logic [1:0] {
		BL_IDLE,
		BL_OFF,
		BL_HOLD
	} epm_blink_state_type;
endpackage : epm_pkg

// ---- src/epm_blink_if.sv ----
interface epm_blink_if;
	logic act;
	logic link;
	logic led_n;
	modport core (output act, output link, input led_n);
	modport timer (input act, input link, output led_n);
endinterface : epm_blink_if

// ---- src/epm_blink.sv ----
module epm_blink import epm_pkg::*; #(
	parameter int unsigned BLINK_LEN = BLINK_CYCLES
) (
	// Clock and control
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Activity and indicator
	epm_blink_if.timer ifc
);
	localparam int CW = $clog2(BLINK_LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(BLINK_LEN - 1);

	epm_blink_state_type st, next_st;
	logic [CW-1:0] cnt, next_cnt;
	logic pend, next_pend;
	logic led_n, next_led_n;

	assign ifc.led_n = led_n;

	// ******************************************************
	// Blink sequencer
	// ******************************************************
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_pend = pend;
		case (st)
			BL_IDLE: begin
				if (ifc.act) begin
					next_st = BL_OFF;
					next_cnt = '0;
				end
			end
			BL_OFF: begin
				if (cnt == LAST) begin
					next_st = BL_HOLD;
					next_cnt = '0;
					next_pend = 1'b0;
				end else begin
					next_cnt = cnt + CW'(1);
				end
			end
			BL_HOLD: begin
				// Activity during the dark-free hold is remembered, not dropped
				next_pend = pend | ifc.act;
				if (cnt == LAST) begin
					next_st = (pend | ifc.act) ? BL_OFF : BL_IDLE;
					next_cnt = '0;
					next_pend = 1'b0;
				end else begin
					next_cnt = cnt + CW'(1);
				end
			end
			default: begin
				next_st = BL_IDLE;
				next_cnt = '0;
				next_pend = 1'b0;
			end
		endcase
		// Lit solid on link, dark for the off phase
		next_led_n = (next_st == BL_OFF) | ~ifc.link;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st <= BL_IDLE;
			cnt <= '0;
			pend <= 1'b0;
			led_n <= RST_LED_N;
		end else if (clk_en) begin
			st <= next_st;
			cnt <= next_cnt;
			pend <= next_pend;
			led_n <= next_led_n;
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_blink_start;
		rst_b && clk_en && st == BL_IDLE && ifc.act;
	endsequence

	sequence s_off_end;
		clk_en && st == BL_OFF && cnt == LAST;
	endsequence

	blink_start_a: assert property (s_blink_start |=> st == BL_OFF && cnt == '0 && led_n)
		else $error("activity did not start the dark phase");
	off_dark_a: assert property (st == BL_OFF |-> led_n)
		else $error("indicator lit during dark phase");
	off_end_a: assert property (s_off_end |=> st == BL_HOLD && cnt == '0)
		else $error("dark phase did not end after its full count");
	link_lit_a: assert property (
		rst_b && clk_en && ifc.link && st == BL_IDLE && !ifc.act |=> !led_n)
		else $error("indicator not lit on link");
endmodule : epm_blink

// ---- tb/epm_board_model.sv ----
module epm_board_model (
	// Memory data pin
	input wire logic data_o,
	input wire logic data_oe,
	input wire logic mem_val,
	output logic data_i,
	// Memory clock pin and strap
	input wire logic clk_o,
	input wire logic clk_oe,
	input wire logic strap_low,
	output logic clk_i,
	// General pins
	input wire logic [2:0] io_o,
	input wire logic [2:0] io_oe,
	input wire logic [2:0] board,
	output logic [2:0] io_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Memory answers whenever the device lets go of the line
	assign data_i = data_oe ? data_o : mem_val;
	// Internal pull-up wins unless the board pulls the strap low
	assign clk_i = clk_oe ? clk_o : !strap_low;
	for (genvar i = 0; i < 3; i++) begin : g_io
		assign io_i[i] = io_oe[i] ? io_o[i] : board[i];
	end
endmodule : epm_board_model

// ---- tb/tb_epm_pin_mux.sv ----
module tb_epm_pin_mux import epm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BL = 10;
	logic clock = 0, rst_b = 0, clk_en = 1, hb_n = 0, g3 = 0, g4 = 0;
	logic [1:0] dsel = 0, csel = 0;
	logic mdo = 0, mdoe = 0, mclk = 0, mcs = 0, mem_val = 0, strap_low = 0;
	logic [5:0] mode = 0;
	logic [2:0] gout = 0, led_en = 0, board = 0, in_st, io_o, io_oe, io_i;
	logic tx_en = 0, tx_clk = 0, rx_dv = 0, rx_clk = 0, link = 0, s100 = 0, an = 0, fd = 0;
	logic strap, strap_v, data_in, d_i, d_o, d_oe, c_i, c_o, c_oe, cs;
	int mismatches = 0, checks = 0, cyc = 0, n;
	logic [31:0] seed = 32'h5DC5;

	epm_pin_mux #(.BLINK_LEN(BL)) i_dut (
		.CLOCK(clock), .RST_B(rst_b), .CLK_EN(clk_en), .HOST_BUS_RESET_N(hb_n),
		.MEM_DATA_SEL(dsel), .MEM_CLK_SEL(csel), .GEN_OUTPUT_THREE(g3), .GEN_OUTPUT_FOUR(g4),
		.GPIO_MODE(mode), .GPIO_OUT(gout), .GPIO_LED_EN(led_en), .GPIO_IN_STATUS(in_st),
		.TEST_STRAP(strap), .STRAP_VALID(strap_v), .MEM_DO(mdo), .MEM_DOE(mdoe),
		.MEM_CLK_OUT(mclk), .MEM_CS_REQ(mcs), .MEM_DATA_IN(data_in), .MII_TX_EN(tx_en),
		.MII_TX_CLK(tx_clk), .MII_RX_DV(rx_dv), .MII_RX_CLK(rx_clk), .LINK_UP(link),
		.SPEED_100(s100), .AUTONEG_BUSY(an), .FULL_DUPLEX(fd), .MEM_SERIAL_DATA_PIN_I(d_i),
		.MEM_SERIAL_DATA_PIN_O(d_o), .MEM_SERIAL_DATA_PIN_OE(d_oe), .MEM_SERIAL_CLOCK_PIN_I(c_i),
		.MEM_SERIAL_CLOCK_PIN_O(c_o), .MEM_SERIAL_CLOCK_PIN_OE(c_oe), .MEM_CHIP_SELECT_PIN(cs),
		.GEN_IO_I(io_i), .GEN_IO_O(io_o), .GEN_IO_OE(io_oe)
	);
	epm_board_model i_board (
		.data_o(d_o), .data_oe(d_oe), .mem_val(mem_val), .data_i(d_i), .clk_o(c_o),
		.clk_oe(c_oe), .strap_low(strap_low), .clk_i(c_i), .io_o(io_o), .io_oe(io_oe),
		.board(board), .io_i(io_i)
	);

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %b want %b", $time, got, exp);
		end
	endtask : chk
	task automatic chk_n(input int got, input int exp);
		checks++;
		if (got != exp) begin
			mismatches++;
			$display("unexpected at %0t: count %0d want %0d", $time, got, exp);
		end
	endtask : chk_n
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input logic lvl);
		strap_low <= !lvl;
		hb_n <= 0;
		rst_b <= 0;
		repeat (10) @(posedge clock);
		rst_b <= 1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk(strap_v, 1'b0);
		chk(strap, RST_STRAP);
		chk(c_oe, 1'b0);
		@(posedge clock);
		hb_n <= 1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk(strap_v, 1'b1);
		chk(strap, lvl);
	endtask : do_reset
	// Counts lit or dark cycles of the link indicator, bounded to catch a stuck pin
	task automatic span(input logic lvl, output int cnt);
		cnt = 0;
		while (io_oe[1] === lvl && cnt < 100) begin
			cnt++;
			@(negedge clock);
		end
	endtask : span
	task automatic rnd_step(input logic en);
		logic [31:0] r;
		logic [14:0] snap;
		logic [3:0] v;
		logic [2:0] lit;
		logic [1:0] md;
		logic eoe, eo;
		@(posedge clock);
		clk_en <= en;
		r = xs();
		{dsel, csel, g3, g4, mdo, mdoe, mclk, mcs, mode, gout, led_en, board} <= r[24:0];
		r = xs();
		{tx_en, tx_clk, rx_dv, rx_clk, link, s100, an, fd, mem_val} <= r[8:0];
		// Taken after the last enabled edge, so only the frozen edges are judged
		@(negedge clock);
		snap = {d_o, d_oe, c_o, c_oe, cs, io_o, io_oe, in_st, data_in};
		repeat (2) @(posedge clock);
		@(negedge clock);
		if (!en) begin
			chk(snap === {d_o, d_oe, c_o, c_oe, cs, io_o, io_oe, in_st, data_in}, 1'b1);
			return;
		end
		v = {tx_clk, tx_en, g3, mdo};
		eoe = dsel != MSEL_MEM || mdoe;
		chk(d_oe, eoe);
		chk(data_in, eoe ? v[dsel] : mem_val);
		v = {rx_clk, rx_dv, g4, mclk};
		chk(c_oe, 1'b1);
		chk(c_o, v[csel]);
		chk(cs, mcs && dsel == MSEL_MEM && csel == MSEL_MEM);
		chk(strap, 1'b0);
		lit = {fd, 1'b0, !(link && !s100 && !an)};
		for (int i = 0; i < 3; i++) begin
			md = mode[2*i+:2];
			if (i == GPIO_LINK && led_en[i])
				continue;
			eoe = led_en[i] ? lit[i] : md == GM_PUSH || (md == GM_OPEN && !gout[i]);
			eo = !led_en[i] && md == GM_PUSH && gout[i];
			chk(io_oe[i], eoe);
			if (eoe)
				chk(io_o[i], eo);
			chk(in_st[i], eoe ? eo : board[i]);
		end
	endtask : rnd_step

	// ****
	// Run
	// ****
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		do_reset(1'b0);
		repeat (300) rnd_step(1'b1);
		rnd_step(1'b0);
		rnd_step(1'b1);
		@(posedge clock);
		link <= 1;
		led_en <= 3'h2;
		tx_en <= 0;
		rx_dv <= 0;
		do_reset(1'b1);
		chk(io_oe[1], 1'b1);
		@(posedge clock);
		tx_en <= 1;
		@(posedge clock);
		tx_en <= 0;
		rx_dv <= 1;
		@(negedge clock);
		span(1'b1, n);
		span(1'b0, n);
		chk_n(n, BL);
		span(1'b1, n);
		chk_n(n, BL);
		@(posedge clock);
		rx_dv <= 0;
		@(negedge clock);
		span(1'b0, n);
		chk_n(n, BL - 1);
		span(1'b1, n);
		chk_n(n, 100);
		@(posedge clock);
		link <= 0;
		repeat (3) @(negedge clock);
		chk(io_oe[1], 1'b0);
		report_and_stop();
	end
endmodule : tb_epm_pin_mux
